/* hdl/psc_command_port.sv */
`timescale 1ns/10ps
// Behaviour
// - Each command is one eight-bit byte, most significant bit first.
// - ADC read returns 24 bits; PROM read returns a 16-bit word.
// - Commands 0xA0..0xAE read PROM; bits 3..1 select the word.
// - Reset command 0x1E loads the PROM into registers and clears state.
// - Commands 0x40..0x48 start pressure conversion; ratio codes 0..4.
// - Commands 0x50..0x58 start temperature conversion with the same ratio field.
// - ADC read after a finished conversion shifts the result out MSB first.
// - ADC read without prior conversion, or repeated, returns zero.
// - ADC read during conversion returns zero and corrupts the final result.
// - Chip select may rise during conversion; conversion continues.
// - PROM holds eight 16-bit words, 128 bits total.
// - Word 0 setup, words 1-6 coefficients, word 7 serial code and CRC.
// - PROM read is command byte then 16-bit word, MSB first.
// - I2C address is 111011C, C being the inverse of chip select.
// - Reset accepted any time; extra clocks free a stuck acknowledge.
// - I2C PROM read is a write transfer then a read transfer.
// - After an I2C conversion command the device stays busy until done.
// - I2C ADC read gives 24 bits; device waits for ack per byte.
// - PROM carries a 4-bit CRC for validity checking.
// - Protocol select low gives SPI, high gives I2C.
// - SPI accepts clock modes 0 and 3.
module psc_command_port #(
    parameter int P_CONV_BASE_CYCLES = psc_pkg::CONV_BASE_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_sclk,
    input wire logic i_protocol_select_pin,
    input wire logic i_chip_select_pin_n,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic [psc_pkg::FUSE_BITS-1:0] i_fuse_words,
    input wire logic [psc_pkg::ADC_BITS-1:0] i_raw_pressure_sample,
    input wire logic [psc_pkg::ADC_BITS-1:0] i_raw_temperature_sample,
    output logic o_conv_busy,
    output logic o_conv_is_temp,
    output logic [psc_pkg::FIELD_W-1:0] o_oversampling_ratio,
    output logic o_prom_loaded
);
    // Command decode, shared by the SPI front end and the core
    function automatic psc_pkg::psc_cmd_s decode(input logic [7:0] b);
        psc_pkg::psc_cmd_s d;
        d.do_reset = (b == psc_pkg::CMD_RESET);
        d.do_adc = (b == psc_pkg::CMD_ADC_READ);
        d.do_prom = (b[7:4] == psc_pkg::PROM_NIBBLE) && !b[psc_pkg::STOP_POS];
        d.do_conv = (b[7:5] == psc_pkg::CONV_TOP) && !b[psc_pkg::STOP_POS]
            && (b[psc_pkg::FIELD_LSB +: psc_pkg::FIELD_W] <= psc_pkg::MAX_RATIO);
        d.is_temp = b[psc_pkg::TYPE_POS];
        d.field = b[psc_pkg::FIELD_LSB +: psc_pkg::FIELD_W];
        return d;
    endfunction

    // Conversion length doubles with each ratio step
    function automatic logic [23:0] conv_cycles(input logic [2:0] r);
        return 24'(P_CONV_BASE_CYCLES) << r;
    endfunction

    function automatic logic [psc_pkg::ADC_BITS-1:0] prom_reply(input logic [psc_pkg::PROM_BITS-1:0] w);
        return {w, {psc_pkg::REPLY_PAD{1'b0}}};
    endfunction

    // Core state, system clock domain
    logic [psc_pkg::PROM_BITS-1:0] prom_q [psc_pkg::PROM_WORDS];
    logic prom_loaded_q;
    logic busy_q;
    logic [23:0] cnt_q;
    logic is_temp_q;
    logic [2:0] ratio_q;
    logic corrupt_q;
    logic [psc_pkg::ADC_BITS-1:0] result_q;
    logic [psc_pkg::ADC_BITS-1:0] reply_q;

    // SPI link domain state
    logic [5:0] spi_cnt_q;
    logic [7:0] spi_in_q;
    logic [psc_pkg::ADC_BITS-1:0] spi_out_q;
    logic spi_sdo_q;
    logic [7:0] spi_cmd_q;
    logic spi_tgl_q;

    // Synchronisers: sclk, sda, chip select, protocol select, command toggle
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic [4:0] prev_q;

    // I2C engine state
    psc_pkg::psc_i2c_e ist_q;
    logic [3:0] ibit_q;
    logic [7:0] ish_q;
    logic [psc_pkg::ADC_BITS-1:0] rd_q;
    logic rw_q;
    logic nack_q;
    logic sda_oe_q;
    logic i2c_ev_q;
    logic [7:0] i2c_rx_q;

    // SPI front end; chip select high or I2C mode holds it cleared
    wire spi_arst = i_chip_select_pin_n | i_protocol_select_pin;
    wire [7:0] spi_byte = {spi_in_q[6:0], i_sdi};
    wire psc_pkg::psc_cmd_s spi_dec = decode(spi_byte);
    wire [psc_pkg::ADC_BITS-1:0] spi_reply = spi_dec.do_adc ? result_q
        : spi_dec.do_prom ? prom_reply(prom_q[spi_dec.field]) : '0;

    // Sample on rising edges, valid for both mode 0 and mode 3
    // result_q and prom_q only move long before a read can sample them,
    // so the reply is taken across as a quasi-static word
    always_ff @(posedge i_sclk or posedge spi_arst) begin
        if (spi_arst) begin
            spi_cnt_q <= 6'h00;
            spi_in_q <= 8'h00;
            spi_out_q <= '0;
        end else begin
            spi_in_q <= spi_byte;
            spi_cnt_q <= (spi_cnt_q == psc_pkg::SPI_END) ? spi_cnt_q : spi_cnt_q + 6'h01;
            spi_out_q <= (spi_cnt_q == psc_pkg::SPI_CMD_LAST) ? spi_reply : spi_out_q << 1;
        end
    end

    // Drive on falling edges so the host samples a settled bit
    always_ff @(negedge i_sclk or posedge spi_arst) begin
        if (spi_arst) begin
            spi_sdo_q <= 1'b0;
        end else begin
            spi_sdo_q <= spi_out_q[psc_pkg::ADC_BITS-1];
        end
    end

    // Complete byte is held and announced by a toggle; survives chip select
    always_ff @(posedge i_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            spi_cmd_q <= 8'h00;
            spi_tgl_q <= 1'b0;
        end else if (!spi_arst && spi_cnt_q == psc_pkg::SPI_CMD_LAST) begin
            spi_cmd_q <= spi_byte;
            spi_tgl_q <= !spi_tgl_q;
        end
    end

    assign o_sdo = spi_sdo_q;
    assign o_sdo_oe = !spi_arst;

    // Pin and toggle synchronisers; only sync_q and prev_q feed logic
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            meta_q <= 5'h03;
            sync_q <= 5'h03;
            prev_q <= 5'h03;
        end else begin
            meta_q <= {spi_tgl_q, i_protocol_select_pin, i_chip_select_pin_n, i_sda, i_sclk};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    wire scl_s = sync_q[0];
    wire sda_s = sync_q[1];
    wire csn_s = sync_q[2];
    wire i2c_mode = sync_q[3];
    wire scl_rise = scl_s && !prev_q[0];
    wire scl_fall = !scl_s && prev_q[0];
    wire i2c_start = scl_s && prev_q[0] && !sda_s && prev_q[1];
    wire i2c_stop = scl_s && prev_q[0] && sda_s && !prev_q[1];
    wire spi_ev = (sync_q[4] != prev_q[4]) && !i2c_mode;
    wire [6:0] my_addr = {psc_pkg::I2C_ADDR_HI, !csn_s};
    wire addr_hit = (ish_q[7:1] == my_addr) && !(ish_q[0] && busy_q);

    // Command selection into the core
    wire cmd_v = spi_ev || i2c_ev_q;
    wire [7:0] core_cmd = spi_ev ? spi_cmd_q : i2c_rx_q;
    wire psc_pkg::psc_cmd_s dec = decode(core_cmd);
    wire conv_done = busy_q && (cnt_q == 24'h000001);
    wire [psc_pkg::ADC_BITS-1:0] sample = is_temp_q ? i_raw_temperature_sample : i_raw_pressure_sample;
    wire [psc_pkg::PROM_BITS-1:0] prom_sel = prom_q[dec.field];

    // Core: conversion timer, result, PROM and reply; reset and ADC read win over completion, a conversion command then is dropped
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            prom_loaded_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= 24'h000000;
            is_temp_q <= 1'b0;
            ratio_q <= 3'h0;
            corrupt_q <= 1'b0;
            result_q <= '0;
            reply_q <= '0;
            for (int k = 0; k < psc_pkg::PROM_WORDS; k++) begin
                prom_q[k] <= '0;
            end
        end else begin
            // Chip select takes no part here, so a deselected host does not stop it
            if (busy_q) begin
                cnt_q <= cnt_q - 24'h000001;
            end
            if (conv_done) begin
                busy_q <= 1'b0;
                result_q <= corrupt_q ? ~sample : sample;
            end
            if (cmd_v && dec.do_reset) begin
                for (int k = 0; k < psc_pkg::PROM_WORDS; k++) begin
                    prom_q[k] <= i_fuse_words[k*psc_pkg::PROM_BITS +: psc_pkg::PROM_BITS];
                end
                prom_loaded_q <= 1'b1;
                busy_q <= 1'b0;
                corrupt_q <= 1'b0;
                result_q <= '0;
                reply_q <= '0;
            end else if (cmd_v && dec.do_conv) begin
                if (busy_q) begin
                    corrupt_q <= 1'b1;
                end else begin
                    busy_q <= 1'b1;
                    cnt_q <= conv_cycles(dec.field);
                    is_temp_q <= dec.is_temp;
                    ratio_q <= dec.field;
                    corrupt_q <= 1'b0;
                    result_q <= '0;
                    reply_q <= '0;
                end
            end else if (cmd_v && dec.do_adc) begin
                reply_q <= busy_q ? '0 : result_q;
                result_q <= '0;
                if (busy_q) begin
                    corrupt_q <= 1'b1;
                end
            end else if (cmd_v && dec.do_prom) begin
                reply_q <= prom_reply(prom_sel);
            end
        end
    end

    assign o_conv_busy = busy_q;
    assign o_conv_is_temp = is_temp_q;
    assign o_oversampling_ratio = ratio_q;
    assign o_prom_loaded = prom_loaded_q;
    assign o_sda = 1'b0;
    assign o_sda_oe = sda_oe_q;

    // I2C engine on oversampled pins; START and STOP override any state
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn || !i2c_mode) begin
            ist_q <= psc_pkg::I2C_IDLE;
            ibit_q <= 4'h0;
            ish_q <= 8'h00;
            rd_q <= '0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            i2c_ev_q <= 1'b0;
            i2c_rx_q <= 8'h00;
        end else begin
            i2c_ev_q <= 1'b0;
            if (i2c_start) begin
                ist_q <= psc_pkg::I2C_ADDR;
                ibit_q <= 4'h0;
                sda_oe_q <= 1'b0;
            end else if (i2c_stop) begin
                ist_q <= psc_pkg::I2C_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                unique case (ist_q)
                    psc_pkg::I2C_IDLE: begin
                        sda_oe_q <= 1'b0;
                    end
                    psc_pkg::I2C_ADDR, psc_pkg::I2C_WRITE: begin
                        if (scl_rise) begin
                            ish_q <= {ish_q[6:0], sda_s};
                            ibit_q <= ibit_q + 4'h1;
                        end else if (scl_fall && ibit_q == psc_pkg::BYTE_DONE) begin
                            if (ist_q == psc_pkg::I2C_WRITE) begin
                                i2c_ev_q <= 1'b1;
                                i2c_rx_q <= ish_q;
                                sda_oe_q <= 1'b1;
                                ist_q <= psc_pkg::I2C_WACK;
                            end else if (addr_hit) begin
                                sda_oe_q <= 1'b1;
                                rw_q <= ish_q[0];
                                ist_q <= psc_pkg::I2C_AACK;
                            end else begin
                                ist_q <= psc_pkg::I2C_IDLE;
                            end
                        end
                    end
                    // Acknowledge is released on the next falling clock,
                    // so extra host clocks always free the data line
                    psc_pkg::I2C_AACK: begin
                        if (scl_fall) begin
                            ibit_q <= 4'h0;
                            if (rw_q) begin
                                rd_q <= reply_q;
                                sda_oe_q <= !reply_q[psc_pkg::ADC_BITS-1];
                                ist_q <= psc_pkg::I2C_READ;
                            end else begin
                                sda_oe_q <= 1'b0;
                                ist_q <= psc_pkg::I2C_WRITE;
                            end
                        end
                    end
                    psc_pkg::I2C_WACK: begin
                        if (scl_fall) begin
                            sda_oe_q <= 1'b0;
                            ibit_q <= 4'h0;
                            ist_q <= psc_pkg::I2C_WRITE;
                        end
                    end
                    psc_pkg::I2C_READ: begin
                        if (scl_rise) begin
                            ibit_q <= ibit_q + 4'h1;
                        end else if (scl_fall && ibit_q == psc_pkg::BYTE_DONE) begin
                            sda_oe_q <= 1'b0;
                            ist_q <= psc_pkg::I2C_MACK;
                        end else if (scl_fall) begin
                            rd_q <= rd_q << 1;
                            sda_oe_q <= !rd_q[psc_pkg::ADC_BITS-2];
                        end
                    end
                    psc_pkg::I2C_MACK: begin
                        if (scl_rise) begin
                            nack_q <= sda_s;
                        end else if (scl_fall && nack_q) begin
                            ist_q <= psc_pkg::I2C_IDLE;
                        end else if (scl_fall) begin
                            rd_q <= rd_q << 1;
                            sda_oe_q <= !rd_q[psc_pkg::ADC_BITS-2];
                            ibit_q <= 4'h0;
                            ist_q <= psc_pkg::I2C_READ;
                        end
                    end
                    default: begin
                        ist_q <= psc_pkg::I2C_IDLE;
                    end
                endcase
            end
        end
    end

    // Checks on the system clock domain
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence seq_conv_cmd;
        cmd_v && dec.do_conv && !dec.do_reset && !busy_q;
    endsequence

    sequence seq_addr_hit;
        i2c_mode && !i2c_start && !i2c_stop && ist_q == psc_pkg::I2C_ADDR
            && scl_fall && ibit_q == psc_pkg::BYTE_DONE && addr_hit;
    endsequence

    a_reset_loads_prom: assert property (cmd_v && dec.do_reset |=> prom_loaded_q && !busy_q
        && prom_q[psc_pkg::CRC_WORD] == $past(i_fuse_words[psc_pkg::FUSE_BITS-1 -: psc_pkg::PROM_BITS]))
        else $error("reset command did not load the calibration words");
    a_conv_start_len: assert property (seq_conv_cmd |=> busy_q
        && cnt_q == conv_cycles($past(core_cmd[psc_pkg::FIELD_LSB +: psc_pkg::FIELD_W])))
        else $error("conversion did not start with the right length");
    a_conv_type: assert property (seq_conv_cmd |=> is_temp_q == $past(core_cmd[psc_pkg::TYPE_POS]))
        else $error("conversion type bit not taken");
    a_conv_done_result: assert property (conv_done && !cmd_v ##0 !corrupt_q
        |=> !busy_q && result_q == $past(sample))
        else $error("finished conversion did not store its sample");
    a_repeat_read_zero: assert property (cmd_v && dec.do_adc ##1 (!conv_done && !cmd_v) |=> result_q == '0)
        else $error("second ADC read would not return zero");
    a_busy_read_zero: assert property (cmd_v && dec.do_adc && busy_q && !conv_done
        |=> reply_q == '0 && corrupt_q)
        else $error("ADC read during conversion not zero or not flagged");
    a_prom_reply_word: assert property (cmd_v && dec.do_prom
        |=> reply_q == prom_reply($past(prom_sel)))
        else $error("PROM reply does not match the selected word");
    a_unknown_ignored: assert property (cmd_v && !dec.do_reset && !dec.do_adc && !dec.do_prom
        && !dec.do_conv && !conv_done |=> $stable(busy_q) && $stable(reply_q) && $stable(result_q))
        else $error("undefined command changed state");
    a_addr_ack_drive: assert property (seq_addr_hit |=> sda_oe_q && ist_q == psc_pkg::I2C_AACK)
        else $error("matching address not acknowledged");
endmodule

/* hdl/psc_pkg.sv */
package psc_pkg;
    // Command byte layout: one byte, most significant bit first on the wire
    localparam int CMD_BITS = 8;
    localparam logic [7:0] CMD_RESET = 8'h1E;
    localparam logic [7:0] CMD_ADC_READ = 8'h00;
    localparam logic [3:0] PROM_NIBBLE = 4'hA;
    localparam logic [2:0] CONV_TOP = 3'h2;
    localparam int PROM_SELECT_POS = 7;
    localparam int CONVERT_SELECT_POS = 6;
    localparam int TYPE_POS = 4;
    localparam int FIELD_LSB = 1;
    localparam int FIELD_W = 3;
    localparam int STOP_POS = 0;
    localparam logic [2:0] MAX_RATIO = 3'h4;

    // Result and calibration storage
    localparam int ADC_BITS = 24;
    localparam int PROM_BITS = 16;
    localparam int PROM_WORDS = 8;
    localparam int REPLY_PAD = ADC_BITS - PROM_BITS;
    localparam int FUSE_BITS = PROM_WORDS * PROM_BITS;
    localparam int CRC_BITS = 4;
    localparam int CRC_WORD = 7;

    // Serial link
    localparam logic [5:0] I2C_ADDR_HI = 6'h3B;
    localparam logic [5:0] SPI_CMD_LAST = 6'h07;
    localparam logic [5:0] SPI_END = 6'h20;
    localparam logic [3:0] BYTE_DONE = 4'h8;

    // Conversion time for the lowest ratio, doubled per ratio step
    localparam int CONV_BASE_US = 500;
    localparam int SYS_CLK_MHZ = 100;
    localparam int CONV_BASE_CYCLES = CONV_BASE_US * SYS_CLK_MHZ;

    typedef struct packed {
        logic do_reset;
        logic do_adc;
        logic do_prom;
        logic do_conv;
        logic is_temp;
        logic [2:0] field;
    } psc_cmd_s;

    typedef enum logic [6:0] {
        I2C_IDLE = 7'h01,
        I2C_ADDR = 7'h02,
        I2C_AACK = 7'h04,
        I2C_WRITE = 7'h08,
        I2C_WACK = 7'h10,
        I2C_READ = 7'h20,
        I2C_MACK = 7'h40
    } psc_i2c_e;
endpackage

/* verification/psc_host_model.sv */
`timescale 1ns/10ps
// Host master on the SPI or I2C link; the link clock stands still between frames
module psc_host_model (
    input wire logic i_sdo,
    input wire logic i_sda,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    output logic o_sda_low
);
    localparam time HALF = 80ns;

    // Idle bus: clock low, SDA released; select rises once at start to clear the link logic
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b0;
        o_sdi = 1'b0;
        o_sda_low = 1'b0;
        #2;
        o_cs_n = 1'b1;
    end

    // One frame: command byte, then clocks for the reply; nbits 8 releases select right after the command
    task automatic spi_frame(input logic [7:0] cmd, input int nbits, input bit mode3, output logic [23:0] rep);
        rep = 24'h000000;
        o_sclk = mode3;
        #HALF;
        o_cs_n = 1'b0;
        #HALF;
        for (int i = 0; i < nbits; i++) begin
            o_sclk = 1'b0;
            o_sdi = (i < 8) ? cmd[7-i] : ~o_sdi;
            #HALF;
            o_sclk = 1'b1;
            if (i >= 8) rep[31-i] = i_sdo;
            #HALF;
        end
        o_sclk = mode3;
        #HALF;
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi; // Released line must not keep its last value
        #(2*HALF);
    endtask

    // I2C clock: SDA moves only in the middle of the low phase, read at the rise
    task automatic i2c_bit(input bit b, output bit s);
        o_sclk = 1'b0;
        #(HALF/2);
        o_sda_low = !b;
        #(HALF/2);
        o_sclk = 1'b1;
        s = i_sda;
        #HALF;
    endtask

    // START from an idle bus; SCL is raised first in case SPI left it low
    task automatic i2c_start();
        o_sda_low = 1'b0;
        o_sclk = 1'b1;
        #HALF;
        o_sda_low = 1'b1;
        #HALF;
    endtask

    task automatic i2c_stop();
        o_sclk = 1'b0;
        #(HALF/2);
        o_sda_low = 1'b1;
        #(HALF/2);
        o_sclk = 1'b1;
        #HALF;
        o_sda_low = 1'b0;
        #HALF;
    endtask

    // Byte out MSB first; the ninth clock reads the device acknowledge
    task automatic i2c_tx(input logic [7:0] b, output bit ack);
        bit s;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(b[i], s);
        end
        i2c_bit(1'b1, s);
        ack = !s;
    endtask

    // Byte in; the host acknowledges all but the last byte
    task automatic i2c_rx(input bit last, output logic [7:0] b);
        bit s;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(1'b1, s);
            b[i] = s;
        end
        i2c_bit(last, s);
    endtask

    // Write transfer: address with write bit, then one command byte
    task automatic i2c_cmd(input logic [6:0] adr, input logic [7:0] cmd, output bit ack);
        bit a;
        i2c_start();
        i2c_tx({adr, 1'b0}, a);
        ack = 1'b0;
        if (a) begin
            i2c_tx(cmd, ack);
        end
        i2c_stop();
    endtask

    // Read transfer of n bytes into the top of rep; stops at once when refused
    task automatic i2c_read(input logic [6:0] adr, input int n, output bit ack, output logic [23:0] rep);
        logic [7:0] b;
        rep = 24'h000000;
        i2c_start();
        i2c_tx({adr, 1'b1}, ack);
        for (int i = 0; i < n && ack; i++) begin
            i2c_rx(i == n - 1, b);
            rep[23 - 8*i -: 8] = b;
        end
        i2c_stop();
    endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
    localparam int BASE = 64;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b1;
    logic sclk, cs_n, sdi, sdo, sdo_oe, sda_o, sda_oe, busy, is_temp, loaded;
    logic [2:0] ratio;
    logic [psc_pkg::FUSE_BITS-1:0] fuse = '0;
    logic [23:0] p_smp = '0;
    logic [23:0] t_smp = '0;
    logic [23:0] rep;
    logic [2:0] r;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int cnt;
    bit t;
    bit ack;
    logic ps = 1'b0;
    logic sda_low;
    // Select stays high in I2C mode, so the address low bit is zero
    localparam logic [6:0] ADR = {psc_pkg::I2C_ADDR_HI, 1'b0};
    wire sda = (sda_oe ? sda_o : 1'b1) & !sda_low; // Open drain with pull-up
    wire miso = sdo_oe ? sdo : ~sdo; // A deselected output carries no valid bit

    always #5 i_sys_clk = ~i_sys_clk;

    psc_host_model host (.i_sdo(miso), .i_sda(sda), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi),
        .o_sda_low(sda_low));

    psc_command_port #(.P_CONV_BASE_CYCLES(BASE)) DUT (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_sclk(sclk), .i_protocol_select_pin(ps),
        .i_chip_select_pin_n(cs_n), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_sda(sda),
        .o_sda(sda_o), .o_sda_oe(sda_oe), .i_fuse_words(fuse), .i_raw_pressure_sample(p_smp),
        .i_raw_temperature_sample(t_smp), .o_conv_busy(busy), .o_conv_is_temp(is_temp),
        .o_oversampling_ratio(ratio), .o_prom_loaded(loaded));

    task automatic summarize();
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard well above the longest expected run
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            summarize();
        end
    end

    // Random clock mode per frame, so both polarities get exercised
    task automatic frame(input logic [7:0] c, input int n);
        host.spi_frame(c, n, 1'($urandom % 2), rep);
    endtask

    task automatic wait_done(input int lim);
        cnt = 0;
        while (busy === 1'b1 && cnt < lim) begin
            @(posedge i_sys_clk);
            cnt++;
        end
    endtask

    function automatic logic [7:0] conv_cmd(input bit tp, input logic [2:0] rt);
        return {2'b01, 1'b0, tp, rt, 1'b0};
    endfunction

    // Fresh samples land just after an edge, never on it
    task automatic new_samples();
        @(posedge i_sys_clk);
        #1;
        p_smp = 24'($urandom);
        t_smp = 24'($urandom);
    endtask

    // Main sequence: reset, calibration reads, every conversion code, then the awkward cases
    initial begin
        void'($urandom(11));
        #1;
        i_rstn = 1'b0; // A real falling edge also clears the link-side command toggle
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_rstn = 1'b1;
        fuse = {$urandom, $urandom, $urandom, $urandom};
        repeat (4) @(posedge i_sys_clk);
        `CHK("prom_loaded", 1'b0, loaded)
        frame(psc_pkg::CMD_RESET, 8);
        repeat (8) @(posedge i_sys_clk);
        `CHK("prom_loaded", 1'b1, loaded)
        for (int k = 0; k < psc_pkg::PROM_WORDS; k++) begin
            frame(8'hA0 | 8'(k << 1), 32);
            `CHK("prom_word", fuse[16*k +: 16], rep[23:8])
            `CHK("prom_pad", 8'h00, rep[7:0])
        end
        frame(psc_pkg::CMD_ADC_READ, 32);
        `CHK("adc_no_conv", 24'h000000, rep)
        for (int j = 0; j < 10; j++) begin
            r = 3'(j % 5);
            t = (j >= 5);
            new_samples();
            frame(conv_cmd(t, r), 8);
            repeat (6) @(posedge i_sys_clk);
            `CHK("busy", 1'b1, busy)
            `CHK("is_temp", t, is_temp)
            `CHK("ratio", r, ratio)
            wait_done((BASE << r) + 8);
            `CHK("conv_time", 1'b1, (cnt + 40 >= (BASE << r)) && busy === 1'b0)
            frame(psc_pkg::CMD_ADC_READ, 32);
            `CHK("adc_result", t ? t_smp : p_smp, rep)
            frame(psc_pkg::CMD_ADC_READ, 32);
            `CHK("adc_repeat", 24'h000000, rep)
        end
        // Read while converting: zero now, inverted sample later
        new_samples();
        frame(conv_cmd(1'b0, psc_pkg::MAX_RATIO), 8);
        frame(psc_pkg::CMD_ADC_READ, 32);
        `CHK("adc_busy", 24'h000000, rep)
        `CHK("still_busy", 1'b1, busy)
        wait_done(BASE << 4);
        frame(psc_pkg::CMD_ADC_READ, 32);
        `CHK("adc_corrupt", ~p_smp, rep)
        // Undefined bytes between a conversion and its read
        new_samples();
        frame(conv_cmd(1'b1, 3'h0), 8);
        wait_done(BASE + 8);
        frame(8'h3C, 8);
        frame(8'hAF, 8);
        frame(8'h41, 8);
        `CHK("undef_busy", 1'b0, busy)
        frame(psc_pkg::CMD_ADC_READ, 32);
        `CHK("undef_keep", t_smp, rep)
        // Reset command in mid-conversion
        frame(conv_cmd(1'b0, psc_pkg::MAX_RATIO), 8);
        frame(psc_pkg::CMD_RESET, 8);
        repeat (8) @(posedge i_sys_clk);
        `CHK("reset_busy", 1'b0, busy)
        frame(psc_pkg::CMD_ADC_READ, 32);
        `CHK("reset_result", 24'h000000, rep)
        `CHK("sdo_released", 1'b0, sdo_oe)
        // I2C: PROM word, foreign address, busy refusal, then the result
        @(posedge i_sys_clk);
        #1;
        ps = 1'b1;
        repeat (4) @(posedge i_sys_clk);
        r = 3'($urandom);
        host.i2c_cmd(ADR, {psc_pkg::PROM_NIBBLE, r, 1'b0}, ack);
        `CHK("i2c_cmd_ack", 1'b1, ack)
        host.i2c_read(ADR, 2, ack, rep);
        `CHK("i2c_prom", fuse[16*r +: 16], rep[23:8])
        host.i2c_cmd(ADR ^ 7'h01, psc_pkg::CMD_RESET, ack);
        `CHK("i2c_other_adr", 1'b0, ack)
        new_samples();
        host.i2c_cmd(ADR, conv_cmd(1'b0, psc_pkg::MAX_RATIO), ack);
        host.i2c_read(ADR, 3, ack, rep);
        `CHK("i2c_busy_nack", 1'b0, ack)
        wait_done(BASE << 4);
        host.i2c_cmd(ADR, psc_pkg::CMD_ADC_READ, ack);
        host.i2c_read(ADR, 3, ack, rep);
        `CHK("i2c_adc", p_smp, rep)
        `CHK("sda_level", 1'b0, sda_o)
        // Port reset in mid-run drops the loaded calibration
        @(posedge i_sys_clk);
        #1;
        i_rstn = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1;
        `CHK("rst_loaded", 1'b0, loaded)
        i_rstn = 1'b1;
        repeat (2) @(posedge i_sys_clk);
        #1;
        `CHK("rst_idle", 1'b0, busy || sda_oe || loaded)
        summarize();
    end
endmodule
